// File: rtl/cmt_color_matrix.sv
// Colour matrix transform stage: correction matrix, saturation, gamma hook,
// luma-chroma conversion and a two-entry output buffer, with APB registers.
// Assumes the gamma stage on gamma_o/gamma_i is combinational.
`timescale 1ns/1ps
module cmt_color_matrix
   import cmt_pkg::*;
#(
   parameter bit COLOR_VARIANT = 1'b1
) (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire cmt_pix_s pix_i,
   input wire logic pix_valid_i,
   output logic pix_ready_o,
   output cmt_pix_s gamma_o,
   input wire cmt_pix_s gamma_i,
   output cmt_pix_s pix_o,
   output logic pix_valid_o,
   input wire logic pix_ready_i
);

   typedef struct packed {
      logic pipe_on;
      logic sel_yuv;
      logic rgb_on;
      logic sat_on;
      logic yuv_fmt;
      logic [2:0] preset;
      logic [3:0] pick;
      logic [7:0] sat;
      logic [15:0] wb_red;
      logic [15:0] wb_blue;
      cmt_coef_set_t user;
      cmt_coef_set_t act_coef;
      logic act_rgb;
      logic act_yuv;
      logic act_sat;
      logic [7:0] act_satv;
      cmt_pix_s [1:0] mem;
      logic wptr;
      logic rptr;
      logic [1:0] count;
      logic [31:0] prdata;
      logic pslverr;
   } cmt_state_s;

   cmt_state_s s_reg;
   cmt_state_s s_next;

   logic fire;
   logic pop;
   logic frame_start;
   logic apb_setup;
   logic apb_wr;
   logic open_ok;
   logic use_rgb;
   logic use_yuv;
   logic use_sat;
   logic [7:0] use_satv;
   logic [7:0] luma;
   cmt_coef_set_t src_coef;
   cmt_coef_set_t use_coef;
   cmt_pix_s stage1;
   cmt_pix_s stage2;
   cmt_pix_s stage3;

   assign pix_ready_o = (s_reg.count != 2'd2);
   assign pix_valid_o = (s_reg.count != 2'd0);
   assign pix_o = s_reg.mem[s_reg.rptr];
   assign fire = pix_valid_i & pix_ready_o;
   assign pop = pix_valid_o & pix_ready_i;
   assign frame_start = fire & pix_i.sof;
   assign apb_setup = psel_i & ~penable_i;
   assign apb_wr = psel_i & penable_i & pwrite_i;
   assign pready_o = 1'b1;
   assign prdata_o = s_reg.prdata;
   assign pslverr_o = s_reg.pslverr;
   // [R10] [R11] settings only reachable with pipeline on, colour variant
   assign open_ok = s_reg.pipe_on & COLOR_VARIANT;

   always_comb begin
      // [R04] [R05] preset table or custom user set
      if (s_reg.preset == CMT_PRESET_CUSTOM) begin
         src_coef = s_reg.user;
      end else begin
         src_coef = CMT_PRESET_COEF[s_reg.preset];
      end
      // [R16] new settings are taken on the first pixel of a frame
      if (frame_start) begin
         use_coef = src_coef;
         use_rgb = open_ok & s_reg.rgb_on;
         use_yuv = open_ok & s_reg.yuv_fmt;
         use_sat = open_ok & s_reg.sat_on;
         use_satv = s_reg.sat;
      end else begin
         use_coef = s_reg.act_coef;
         use_rgb = s_reg.act_rgb;
         use_yuv = s_reg.act_yuv;
         use_sat = s_reg.act_sat;
         use_satv = s_reg.act_satv;
      end
   end

   always_comb begin
      // [R03] correction applied or bypassed
      stage1 = use_rgb ? cmt_apply(pix_i, use_coef) : pix_i;
      luma = 8'((10'(stage1.r) + 10'({stage1.g, 1'b0}) + 10'(stage1.b)) >> 2);
      // [R09] saturation only when enabled
      stage2 = stage1;
      if (use_sat) begin
         stage2.r = cmt_sat_ch(stage1.r, luma, use_satv);
         stage2.g = cmt_sat_ch(stage1.g, luma, use_satv);
         stage2.b = cmt_sat_ch(stage1.b, luma, use_satv);
      end
      gamma_o = stage2;
      // [R06] [R07] luma-chroma after gamma, for YUV formats only
      stage3 = use_yuv ? cmt_apply(gamma_i, CMT_YUV_COEF) : gamma_i;
   end

   always_comb begin
      s_next = s_reg;
      s_next.act_coef = use_coef;
      s_next.act_rgb = use_rgb;
      s_next.act_yuv = use_yuv;
      s_next.act_sat = use_sat;
      s_next.act_satv = use_satv;
      if (fire) begin
         s_next.mem[s_reg.wptr] = stage3;
         s_next.wptr = ~s_reg.wptr;
      end
      if (pop) begin
         s_next.rptr = ~s_reg.rptr;
      end
      s_next.count = 2'(s_reg.count + {1'b0, fire} - {1'b0, pop});

      if (apb_setup) begin
         s_next.prdata = 32'h0000_0000;
         s_next.pslverr = 1'b0;
         unique case (paddr_i)
            CMT_CTRL_OFS: begin
               s_next.prdata[CMT_PIPE_ON_BIT] = s_reg.pipe_on;
               s_next.prdata[CMT_SELECT_BIT] = s_reg.sel_yuv;
               // [R13] shows the format-driven state when luma-chroma selected
               s_next.prdata[CMT_ON_BIT] = s_reg.sel_yuv ? s_reg.yuv_fmt : s_reg.rgb_on;
               s_next.prdata[CMT_SAT_ON_BIT] = s_reg.sat_on;
               s_next.prdata[CMT_YUV_FMT_BIT] = s_reg.yuv_fmt;
               s_next.prdata[CMT_PRESET_LSB +: 3] = s_reg.preset;
            end
            CMT_PICK_OFS: s_next.prdata[3:0] = s_reg.pick;
            CMT_VALUE_OFS: begin
               // [R02] [R08] coefficient in use for the selected transform
               if (s_reg.pick <= CMT_PICK_LAST) begin
                  s_next.prdata = s_reg.sel_yuv ? 32'(CMT_YUV_COEF[s_reg.pick]) :
                     32'(s_reg.act_coef[s_reg.pick]);
               end
            end
            CMT_SAT_OFS: s_next.prdata[7:0] = s_reg.sat;
            CMT_WB_OFS: s_next.prdata = {s_reg.wb_blue, s_reg.wb_red};
            CMT_STATUS_OFS: s_next.prdata[5:0] = {s_reg.count, 1'b0, s_reg.act_sat,
               s_reg.act_yuv, s_reg.act_rgb};
            default: s_next.pslverr = 1'b1;
         endcase
         if (!open_ok && paddr_i != CMT_CTRL_OFS) begin
            s_next.prdata = 32'h0000_0000;
            s_next.pslverr = 1'b1;
         end
      end

      if (apb_wr && paddr_i == CMT_CTRL_OFS) begin
         s_next.pipe_on = pwdata_i[CMT_PIPE_ON_BIT];
         if (open_ok) begin
            s_next.sel_yuv = pwdata_i[CMT_SELECT_BIT];
            // [R13] enable write ignored while luma-chroma selected
            if (!s_reg.sel_yuv) begin
               s_next.rgb_on = pwdata_i[CMT_ON_BIT];
            end
            s_next.sat_on = pwdata_i[CMT_SAT_ON_BIT];
            s_next.yuv_fmt = pwdata_i[CMT_YUV_FMT_BIT];
            s_next.preset = pwdata_i[CMT_PRESET_LSB +: 3];
            // [R14] change to a non-custom preset loads white-balance ratios
            if (pwdata_i[CMT_PRESET_LSB +: 3] != s_reg.preset &&
                pwdata_i[CMT_PRESET_LSB +: 3] != CMT_PRESET_CUSTOM) begin
               s_next.wb_red = CMT_PRESET_WB[pwdata_i[CMT_PRESET_LSB +: 3]][15:0];
               s_next.wb_blue =
                  CMT_PRESET_WB[pwdata_i[CMT_PRESET_LSB +: 3]][CMT_WB_BLUE_LSB +: 16];
            end
         end
      end else if (apb_wr && open_ok) begin
         unique case (paddr_i)
            // [R12] entry picker, gains row-major then offsets
            CMT_PICK_OFS: s_next.pick = pwdata_i[3:0];
            CMT_VALUE_OFS: begin
               // [R05] user entries written only for the correction matrix
               if (!s_reg.sel_yuv && s_reg.pick <= CMT_PICK_LAST) begin
                  s_next.user[s_reg.pick] = pwdata_i[11:0];
               end
            end
            CMT_SAT_OFS: s_next.sat = pwdata_i[7:0];
            CMT_WB_OFS: begin
               s_next.wb_red = pwdata_i[15:0];
               s_next.wb_blue = pwdata_i[CMT_WB_BLUE_LSB +: 16];
            end
            default: begin
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         s_reg <= '0;
         s_reg.preset <= CMT_PRESET_RST;
         s_reg.sat <= CMT_SAT_RST;
         s_reg.act_satv <= CMT_SAT_RST;
         s_reg.wb_red <= CMT_WB_RST;
         s_reg.wb_blue <= CMT_WB_RST;
         s_reg.user <= CMT_IDENTITY;
         s_reg.act_coef <= CMT_IDENTITY;
      end else begin
         s_reg <= s_next;
      end
   end

   default clocking cb @(posedge ref_clk_i);
   endclocking
   default disable iff (rst_i);

   bypass_path_a: assert property ( // [R03]
      fire && !use_rgb && !use_sat && !use_yuv |=> pix_o == $past(pix_i) || s_reg.count == 2'd2)
      else $error("bypassed pixel altered");

   matrix_result_a: assert property ( // [R01]
      fire && use_rgb && !use_sat && !use_yuv && s_reg.count == 2'd0 && !pix_ready_i
      |=> pix_o == cmt_apply($past(pix_i), $past(use_coef)))
      else $error("matrix output wrong");

   frame_hold_a: assert property ( // [R16]
      $changed(s_reg.act_coef) || $changed(s_reg.act_rgb) |-> $past(frame_start))
      else $error("coefficients changed mid frame");

   yuv_format_a: assert property ( // [R07]
      $changed(s_reg.act_yuv) |->
      $past(frame_start) && s_reg.act_yuv == $past(open_ok && s_reg.yuv_fmt))
      else $error("luma-chroma switched without format");

   closed_error_a: assert property ( // [R10]
      apb_setup && !open_ok && paddr_i != CMT_CTRL_OFS |=> pslverr_o && prdata_o == 32'h0)
      else $error("closed access not refused");

   enable_readonly_a: assert property ( // [R13]
      apb_wr && paddr_i == CMT_CTRL_OFS && s_reg.sel_yuv |=> $stable(s_reg.rgb_on))
      else $error("enable written while read-only");

   preset_balance_a: assert property ( // [R14]
      apb_wr && paddr_i == CMT_CTRL_OFS && open_ok &&
      pwdata_i[CMT_PRESET_LSB +: 3] != s_reg.preset &&
      pwdata_i[CMT_PRESET_LSB +: 3] != CMT_PRESET_CUSTOM
      |=> s_reg.wb_red == CMT_PRESET_WB[s_reg.preset][15:0])
      else $error("preset did not load balance");

   value_readback_a: assert property ( // [R08]
      apb_setup && open_ok && paddr_i == CMT_VALUE_OFS && !s_reg.sel_yuv &&
      s_reg.pick <= CMT_PICK_LAST
      |=> prdata_o == 32'($past(s_reg.act_coef[s_reg.pick])))
      else $error("readback not coefficient in use");

   custom_write_a: assert property ( // [R05]
      apb_wr && open_ok && paddr_i == CMT_VALUE_OFS && !s_reg.sel_yuv &&
      s_reg.pick <= CMT_PICK_LAST
      |=> s_reg.user[$past(s_reg.pick)] == $past(pwdata_i[11:0]))
      else $error("custom entry not stored");

   buffer_full_a: assert property (
      s_reg.count == 2'd2 && !pix_ready_i |=> !pix_ready_o && $stable(pix_o))
      else $error("full buffer not stalling");

endmodule

// File: rtl/cmt_pkg.sv
// Constants, types and helper functions for the colour matrix transform stage.
// Assumes one pixel clock, 8-bit RGB pixels and an APB register port.
// Operation
// [R01] Output channels: 3x3 gain times RGB plus offsets
// [R02] Two transforms, each with own coefficient set
// [R03] Transform enable bypasses or applies RGB correction
// [R04] Illuminant preset picks calibrated RGB matrix
// [R05] Custom preset uses user-written coefficient entries
// [R06] Luma-chroma conversion follows correction and gamma
// [R07] Luma-chroma active only for YUV pixel formats
// [R08] Selected coefficient in use reads back
// [R09] Saturation applied only when enabled; larger vivid
// [R10] Settings accessible only while image pipeline on
// [R11] Stage present only on standard colour variants
// [R12] Picker: nine gains row-major, three offsets
// [R13] Transform enable read-only when luma-chroma selected
// [R14] Preset choice also loads white-balance ratios
// [R15] Signed fixed-point coefficients, outputs clamped
// [R16] Coefficient updates take effect at frame start
package cmt_pkg;

   typedef logic signed [11:0] cmt_coef_t;
   typedef cmt_coef_t [11:0] cmt_coef_set_t;
   typedef cmt_coef_set_t [6:0] cmt_preset_tab_t;

   typedef struct packed {
      logic sof;
      logic [7:0] r;
      logic [7:0] g;
      logic [7:0] b;
   } cmt_pix_s;

   // Register byte offsets
   localparam logic [7:0] CMT_CTRL_OFS = 8'h00;
   localparam logic [7:0] CMT_PICK_OFS = 8'h04;
   localparam logic [7:0] CMT_VALUE_OFS = 8'h08;
   localparam logic [7:0] CMT_SAT_OFS = 8'h0c;
   localparam logic [7:0] CMT_WB_OFS = 8'h10;
   localparam logic [7:0] CMT_STATUS_OFS = 8'h14;

   // Control register fields, and blue field of the white-balance register
   localparam int CMT_PIPE_ON_BIT = 0;
   localparam int CMT_SELECT_BIT = 1;
   localparam int CMT_ON_BIT = 2;
   localparam int CMT_SAT_ON_BIT = 3;
   localparam int CMT_YUV_FMT_BIT = 4;
   localparam int CMT_PRESET_LSB = 8;
   localparam int CMT_WB_BLUE_LSB = 16;

   // Reset values
   localparam logic [2:0] CMT_PRESET_RST = 3'h0;
   localparam logic [7:0] CMT_SAT_RST = 8'h80;
   localparam logic [15:0] CMT_WB_RST = 16'h0100;

   localparam logic [2:0] CMT_PRESET_CUSTOM = 3'h7;
   localparam logic [3:0] CMT_PICK_LAST = 4'hb;
   localparam logic [3:0] CMT_OFFSET_BASE = 4'h9;
   localparam int CMT_FRAC = 8;
   localparam int CMT_SAT_FRAC = 7;

   // Entry order {off2,off1,off0,g22,g21,g20,g12,g11,g10,g02,g01,g00}
   localparam cmt_coef_set_t CMT_IDENTITY = {12'sh000, 12'sh000, 12'sh000,
      12'sh100, 12'sh000, 12'sh000, 12'sh000, 12'sh100, 12'sh000,
      12'sh000, 12'sh000, 12'sh100};
   localparam cmt_coef_set_t CMT_YUV_COEF = {12'sh080, 12'sh080, 12'sh000,
      12'sh000, 12'shf80, 12'sh080, 12'sh080, 12'shf80, 12'sh000,
      12'sh040, 12'sh080, 12'sh040};
   localparam cmt_preset_tab_t CMT_PRESET_COEF = {7{CMT_IDENTITY}};
   localparam logic [6:0][31:0] CMT_PRESET_WB = {7{32'h0100_0100}};

   // [R15] clamp to pixel range
   function automatic logic [7:0] cmt_clamp(input logic signed [22:0] v);
      if (v < 0) begin
         return 8'h00;
      end else if (v > 23'sd255) begin
         return 8'hff;
      end
      return v[7:0];
   endfunction

   // [R01] one output channel
   function automatic logic [7:0] cmt_mac(input cmt_coef_t g0, input cmt_coef_t g1,
      input cmt_coef_t g2, input cmt_coef_t off, input cmt_pix_s p);
      logic signed [22:0] acc;
      acc = g0 * $signed({1'b0, p.r}) + g1 * $signed({1'b0, p.g}) + g2 * $signed({1'b0, p.b});
      acc = (acc >>> CMT_FRAC) + 23'(off);
      return cmt_clamp(acc);
   endfunction

   function automatic cmt_pix_s cmt_apply(input cmt_pix_s p, input cmt_coef_set_t c);
      cmt_pix_s q;
      q.sof = p.sof;
      q.r = cmt_mac(c[0], c[1], c[2], c[9], p);
      q.g = cmt_mac(c[3], c[4], c[5], c[10], p);
      q.b = cmt_mac(c[6], c[7], c[8], c[11], p);
      return q;
   endfunction

   // [R09] push channel away from luma by the saturation factor
   function automatic logic [7:0] cmt_sat_ch(input logic [7:0] c, input logic [7:0] y,
      input logic [7:0] s);
      logic signed [22:0] d;
      d = 23'($signed({1'b0, c})) - 23'($signed({1'b0, y}));
      d = 23'($signed({1'b0, y})) + ((d * $signed({1'b0, s})) >>> CMT_SAT_FRAC);
      return cmt_clamp(d);
   endfunction

endpackage

// File: verif/cmt_pix_sink.sv
// Downstream pixel stage model: accepts words with random stalls.
// Assumes the testbench seeds the random generator once at time zero.
`timescale 1ns/1ps
module cmt_pix_sink (
   input wire logic ref_clk_i,
   input wire logic rst_i,
   input wire logic hold_i,
   output logic ready_o
);
   // Hold forces a full stall so the output buffer can fill
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         ready_o <= 1'b0;
      end else begin
         ready_o <= !hold_i && ($urandom % 3 != 0);
      end
   end
endmodule

// File: verif/color_matrix_transform_tb.sv
// Self-checking bench for the colour matrix stage: APB set-up, pixel frames.
// Assumes a combinational gamma stage, looped here as gamma_i = gamma_o.
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((e) !== (s)) begin failures++; \
   $display("wrong value %s expected %h seen %h", nm, e, s); end end
module color_matrix_transform_tb;
   import cmt_pkg::*;
   logic ref_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic psel_i = 1'b0;
   logic penable_i = 1'b0;
   logic pwrite_i = 1'b0;
   logic [7:0] paddr_i = 8'h00;
   logic [31:0] pwdata_i = 32'h0;
   logic [31:0] prdata_o;
   logic pready_o, pslverr_o, pix_ready_o, pix_valid_o, pix_ready_i;
   logic pix_valid_i = 1'b0;
   logic hold = 1'b0;
   cmt_pix_s pix_i = '0;
   cmt_pix_s gamma_o, pix_o, e;
   cmt_pix_s exp_q[$];
   int failures = 0;
   int n_tests = 0;
   int mode = 0;
   always #25 ref_clk_i = ~ref_clk_i;
   cmt_color_matrix i_dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .psel_i(psel_i),
      .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
      .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pix_i(pix_i),
      .pix_valid_i(pix_valid_i), .pix_ready_o(pix_ready_o), .gamma_o(gamma_o),
      .gamma_i(gamma_o), .pix_o(pix_o), .pix_valid_o(pix_valid_o), .pix_ready_i(pix_ready_i));
   cmt_pix_sink i_sink (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .hold_i(hold),
      .ready_o(pix_ready_i));
   task automatic stop_test();
      if (failures == 0 && n_tests > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   function automatic logic [7:0] clip(input int v);
      return (v < 0) ? 8'h00 : (v > 255) ? 8'hff : 8'(v);
   endfunction
   // Reference result for the current mode: 0 bypass, 1 custom, 2 luma-chroma, 3 grey
   function automatic cmt_pix_s expect_pix(input cmt_pix_s p);
      cmt_pix_s q;
      int y;
      q = p;
      y = (int'(p.r) + 2 * int'(p.g) + int'(p.b)) >>> 2;
      case (mode)
         1: begin
            q.r = clip(2 * int'(p.r));
            q.b = clip(int'(p.b) - 16);
         end
         2: begin
            q.r = clip(y);
            q.g = clip((((int'(p.b) - int'(p.g)) * 128) >>> 8) + 128);
            q.b = clip((((int'(p.r) - int'(p.g)) * 128) >>> 8) + 128);
         end
         3: begin
            q.r = clip(y);
            q.g = clip(y);
            q.b = clip(y);
         end
         default: q = p;
      endcase
      return q;
   endfunction
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] rd, output logic er);
      int k;
      psel_i <= 1'b1;
      penable_i <= 1'b0;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge ref_clk_i);
      penable_i <= 1'b1;
      k = 0;
      do begin
         @(posedge ref_clk_i);
         k++;
      end while (pready_o !== 1'b1 && k < 20);
      if (k >= 20) begin
         failures++;
         stop_test();
      end
      rd = prdata_o;
      er = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] rd;
      logic er;
      apb(1'b1, a, d, rd, er);
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
      logic [31:0] rd;
      logic er;
      apb(1'b0, a, 0, rd, er);
      `CHK("read data", x, rd)
      `CHK("read error", xe, er)
   endtask
   task automatic send(input logic sof);
      cmt_pix_s p;
      int k;
      p = {sof, 8'($urandom), 8'($urandom), 8'($urandom)};
      pix_i <= p;
      pix_valid_i <= 1'b1;
      exp_q.push_back(expect_pix(p));
      k = 0;
      do begin
         @(negedge ref_clk_i);
         k++;
      end while (pix_ready_o !== 1'b1 && k < 50);
      if (k >= 50) begin
         failures++;
         stop_test();
      end
      @(posedge ref_clk_i);
   endtask
   task automatic frame(input int n);
      send(1'b1);
      repeat (n - 1) send(1'b0);
      pix_valid_i <= 1'b0;
      @(posedge ref_clk_i);
   endtask
   task automatic drain();
      int k;
      k = 0;
      while (exp_q.size() > 0 && k < 200) begin
         @(posedge ref_clk_i);
         k++;
      end
      if (k >= 200) begin
         failures++;
         stop_test();
      end
   endtask
   // Each accepted output word is checked against the oldest expectation
   always @(negedge ref_clk_i) begin
      if (pix_valid_o === 1'b1 && pix_ready_i === 1'b1) begin
         if (exp_q.size() == 0) begin
            e = 'x;
         end else begin
            e = exp_q.pop_front();
         end
         `CHK("pixel", e, pix_o)
      end
   end
   initial begin
      void'($urandom(421));
      repeat (5) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      @(posedge ref_clk_i);
      rd_chk(CMT_SAT_OFS, 32'h0, 1'b1);
      wr(CMT_CTRL_OFS, 32'h1);
      rd_chk(CMT_SAT_OFS, 32'h80, 1'b0);
      rd_chk(8'h18, 32'h0, 1'b1);
      frame(6);
      wr(CMT_CTRL_OFS, 32'h705);
      wr(CMT_PICK_OFS, 32'h0);
      wr(CMT_VALUE_OFS, 32'h200);
      wr(CMT_PICK_OFS, 32'hb);
      wr(CMT_VALUE_OFS, 32'hff0);
      mode = 1;
      frame(8);
      drain();
      hold <= 1'b1;
      @(posedge ref_clk_i);
      send(1'b0);
      send(1'b0);
      pix_valid_i <= 1'b0;
      @(negedge ref_clk_i);
      `CHK("buffer full", 1'b0, pix_ready_o)
      @(posedge ref_clk_i);
      hold <= 1'b0;
      rd_chk(CMT_VALUE_OFS, 32'hfffffff0, 1'b0);
      wr(CMT_PICK_OFS, 32'h0);
      rd_chk(CMT_VALUE_OFS, 32'h200, 1'b0);
      drain();
      wr(CMT_SAT_OFS, 32'h0);
      wr(CMT_WB_OFS, 32'h0123_0456);
      wr(CMT_CTRL_OFS, 32'h9);
      rd_chk(CMT_WB_OFS, 32'h0100_0100, 1'b0);
      mode = 3;
      frame(6);
      drain();
      wr(CMT_CTRL_OFS, 32'h13);
      rd_chk(CMT_CTRL_OFS, 32'h17, 1'b0);
      rd_chk(CMT_VALUE_OFS, 32'h40, 1'b0);
      mode = 2;
      frame(10);
      drain();
      rd_chk(CMT_STATUS_OFS, 32'h2, 1'b0);
      // Enable bit must be ignored while the luma-chroma transform is selected
      wr(CMT_CTRL_OFS, 32'h17);
      wr(CMT_CTRL_OFS, 32'h1);
      rd_chk(CMT_CTRL_OFS, 32'h1, 1'b0);
      stop_test();
   end
endmodule
